// file: hw/pfm_monitor.sv
// phase fault monitor: dropout, sequence, reverse power, led mux
`default_nettype none
module pfm_monitor
  import pfm_pkg::*;
#(
  parameter int DROP_LIMIT = DROP_CYC,
  parameter int BLINK_HALF = BLINK_HALF_CYC,
  parameter int SEL_HALF = SEL_HALF_CYC,
  parameter int FILT = SUPPLY_FILT_CYC
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic supply_above,
  input wire logic supply_below,
  input wire logic ref_above,
  input wire pfm_phase_in_type phase_in,
  input wire logic signed [PWR_W-1:0] power_a,
  input wire logic signed [PWR_W-1:0] power_b,
  input wire logic signed [PWR_W-1:0] power_c,
  output pfm_led_type led,
  output logic signed [PWR_W+1:0] total_power,
  output logic datapath_rst
);
  ////////////////////////////////////////////////////////////////////////
  // supply monitor: pins synchronised, filtered, hysteresis
  logic [2:0] s1_r, s2_r;
  logic good_r, good_nxt;
  logic [$clog2(FILT+1)-1:0] filt_r, filt_nxt;

  always_comb
  begin
    good_nxt = good_r;
    filt_nxt = filt_r;
    // set on upper comparator together with reference, drop on lower one or loss of reference
    if (!good_r && s2_r[0] && s2_r[2])
    begin
      filt_nxt = filt_r + 1'b1;
      if (filt_r == ($clog2(FILT+1))'(FILT - 1))
      begin
        good_nxt = 1'b1;
        filt_nxt = '0;
      end
    end
    else if (good_r && (s2_r[1] || !s2_r[2]))
    begin
      filt_nxt = filt_r + 1'b1;
      if (filt_r == ($clog2(FILT+1))'(FILT - 1))
      begin
        good_nxt = 1'b0;
        filt_nxt = '0;
      end
    end
    else
      filt_nxt = '0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      good_r <= 1'b0;
      filt_r <= '0;
    end
    else
    begin
      s1_r <= {ref_above, supply_below, supply_above};
      s2_r <= s1_r;
      good_r <= good_nxt;
      filt_r <= filt_nxt;
    end
  end

  logic dp_rst;
  assign dp_rst = rst | ~good_r;
  assign datapath_rst = dp_rst;

  ////////////////////////////////////////////////////////////////////////
  // per-phase dropout detection; inputs are same-clock, no sync
  logic [NPH-1:0] drop;
  genvar g;
  generate
    for (g = 0; g < NPH; g++)
    begin : gen_ph
      pfm_timer #(.LIMIT(DROP_LIMIT)) u_timer (
        .core_clk(core_clk),
        .rst(dp_rst),
        .zc(phase_in.zero_cross[g]),
        .amp_ok(phase_in.amp_ok[g]),
        .dropout(drop[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // sequence tracking
  typedef enum logic [1:0] {
    PFM_EXP_A = 2'h0,
    PFM_EXP_B = 2'h1,
    PFM_EXP_C = 2'h2
  } pfm_exp_type;
  pfm_exp_type exp_r, exp_nxt;
  logic bad_r, bad_nxt;
  logic seq_err_r, seq_err_nxt;
  logic [$clog2(DROP_LIMIT+2)-1:0] sdel_r, sdel_nxt;
  logic any_drop;
  logic [1:0] zc_idx;
  logic zc_any;
  assign any_drop = |drop;
  assign zc_any = |phase_in.zero_cross;

  always_comb
  begin
    zc_idx = PH_A;
    if (phase_in.zero_cross[2])
      zc_idx = PH_C;
    else if (phase_in.zero_cross[1])
      zc_idx = PH_B;
  end

  always_comb
  begin
    exp_nxt = exp_r;
    bad_nxt = bad_r;
    seq_err_nxt = seq_err_r;
    sdel_nxt = sdel_r;
    if (zc_any)
    begin
      // next expected follows the crossing seen: resync after a slip
      bad_nxt = (zc_idx != exp_r);
      unique case (zc_idx)
        PH_A: exp_nxt = PFM_EXP_B;
        PH_B: exp_nxt = PFM_EXP_C;
        default: exp_nxt = PFM_EXP_A;
      endcase
    end
    if (any_drop)
    begin
      bad_nxt = 1'b0;
      seq_err_nxt = 1'b0;
      sdel_nxt = '0;
    end
    else if (bad_r)
    begin
      // error must persist ~150 ms before blinking
      if (sdel_r >= ($clog2(DROP_LIMIT+2))'(DROP_LIMIT))
        seq_err_nxt = 1'b1;
      else
        sdel_nxt = sdel_r + 1'b1;
    end
    else
    begin
      sdel_nxt = '0;
      seq_err_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (dp_rst)
    begin
      exp_r <= PFM_EXP_A;
      bad_r <= 1'b0;
      seq_err_r <= 1'b0;
      sdel_r <= '0;
    end
    else
    begin
      exp_r <= exp_nxt;
      bad_r <= bad_nxt;
      seq_err_r <= seq_err_nxt;
      sdel_r <= sdel_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dividers: select toggle and 1 Hz blink
  logic [$clog2(SEL_HALF+1)-1:0] sdiv_r, sdiv_nxt;
  logic sel_r, sel_nxt;
  logic [$clog2(BLINK_HALF+1)-1:0] bdiv_r, bdiv_nxt;
  logic blink_r, blink_nxt;

  always_comb
  begin
    sdiv_nxt = sdiv_r + 1'b1;
    sel_nxt = sel_r;
    bdiv_nxt = bdiv_r + 1'b1;
    blink_nxt = blink_r;
    if (sdiv_r == ($clog2(SEL_HALF+1))'(SEL_HALF - 1))
    begin
      sdiv_nxt = '0;
      sel_nxt = ~sel_r;
    end
    if (bdiv_r == ($clog2(BLINK_HALF+1))'(BLINK_HALF - 1))
    begin
      bdiv_nxt = '0;
      blink_nxt = ~blink_r;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (dp_rst)
    begin
      sdiv_r <= '0;
      sel_r <= 1'b0;
      bdiv_r <= '0;
      blink_r <= 1'b0;
    end
    else
    begin
      sdiv_r <= sdiv_nxt;
      sel_r <= sel_nxt;
      bdiv_r <= bdiv_nxt;
      blink_r <= blink_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // led multiplexing: low = lit on select high, high = lit on select low
  logic [NPH-1:0] pin_nxt, pin_r;
  logic [NPH-1:0] top_on;
  always_comb
  begin
    // dropout wins; sequence only when no dropout
    top_on = any_drop ? drop : {NPH{seq_err_r & blink_r}};
    // next select value decides which led the pin serves
    pin_nxt = sel_nxt ? ~top_on : phase_in.power_neg;
    if (dp_rst)
      pin_nxt = '0;
  end

  logic sel_out_r;
  always_ff @(posedge core_clk)
  begin
    if (dp_rst)
    begin
      pin_r <= '0;
      sel_out_r <= 1'b0;
    end
    else
    begin
      pin_r <= pin_nxt;
      sel_out_r <= sel_nxt;
    end
  end

  assign led.indicator_select = sel_out_r;
  assign led.phase_a_indicator = pin_r[0];
  assign led.phase_b_indicator = pin_r[1];
  assign led.phase_c_indicator = pin_r[2];

  ////////////////////////////////////////////////////////////////////////
  // total active power; runs regardless of dropout
  logic signed [PWR_W+1:0] tot_r, tot_nxt;
  always_comb
  begin
    tot_nxt = (PWR_W+2)'(power_a) + (PWR_W+2)'(power_b)
      + (PWR_W+2)'(power_c);
  end
  always_ff @(posedge core_clk)
  begin
    if (dp_rst)
      tot_r <= '0;
    else
      tot_r <= tot_nxt;
  end
  assign total_power = tot_r;

  ////////////////////////////////////////////////////////////////////////
  chk_drop_lit: assert property (@(posedge core_clk)
    disable iff (dp_rst)
    sel_out_r && $past(drop[0]) && !$past(dp_rst) |-> !pin_r[0])
    else $error("dropped phase a led not lit");
  chk_rev_lit: assert property (@(posedge core_clk)
    disable iff (dp_rst)
    !sel_out_r && !$past(dp_rst) |-> pin_r[1] == $past(phase_in.power_neg[1]))
    else $error("reverse phase_b_indicator wrong");
  chk_seq_gate: assert property (@(posedge core_clk)
    disable iff (dp_rst) any_drop |=> !seq_err_r)
    else $error("sequence error shown during dropout");
  chk_prio: assert property (@(posedge core_clk)
    disable iff (dp_rst) sel_out_r && $past(drop == 3'h1) && !$past(dp_rst)
    |-> pin_r[2:1] == 2'h3)
    else $error("sequence blink beat dropout");
  chk_sel_toggle: assert property (@(posedge core_clk)
    disable iff (dp_rst) $changed(sel_out_r) |=> !$changed(sel_out_r))
    else $error("select toggled too fast");
  chk_off_rst: assert property (@(posedge core_clk)
    dp_rst |=> pin_r == '0 && !sel_out_r)
    else $error("outputs active in reset");
  chk_sum: assert property (@(posedge core_clk)
    disable iff (dp_rst) !$past(dp_rst)
    |-> tot_r == $past(power_a) + $past(power_b) + $past(power_c))
    else $error("total power wrong");
  chk_seq_delay: assert property (@(posedge core_clk)
    disable iff (dp_rst)
    $rose(seq_err_r) |-> $past(bad_r) && $past(sdel_r) >= DROP_LIMIT)
    else $error("blink without pending error");
  cov_drop: cover property (@(posedge core_clk) $rose(drop[0]));
  cov_seq: cover property (@(posedge core_clk) $rose(seq_err_r));
  cov_rev: cover property (@(posedge core_clk) pin_r[1] && !sel_out_r);
  cov_good: cover property (@(posedge core_clk) $rose(good_r));
endmodule : pfm_monitor
`default_nettype wire

// file: hw/pfm_pkg.sv
// package for the phase fault monitor: types and timing constants
`default_nettype none
package pfm_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int SEL_RATE_HZ = 131_000;
  // half period of the select toggle, rounded down
  localparam int SEL_HALF_CYC = CLK_HZ / (2 * SEL_RATE_HZ);
  localparam int DROP_TIME_MS = 150;
  localparam int DROP_CYC = (CLK_HZ / 1000) * DROP_TIME_MS;
  localparam int BLINK_RATE_HZ = 1;
  localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_RATE_HZ);
  localparam int SUPPLY_FILT_CYC = 16;
  localparam int PWR_W = 24;
  localparam int NPH = 3;
  localparam logic [1:0] PH_A = 2'h0;
  localparam logic [1:0] PH_B = 2'h1;
  localparam logic [1:0] PH_C = 2'h2;
  typedef struct packed {
    logic [NPH-1:0] zero_cross;
    logic [NPH-1:0] amp_ok;
    logic [NPH-1:0] power_neg;
  } pfm_phase_in_type;
  typedef struct packed {
    logic indicator_select;
    logic phase_a_indicator;
    logic phase_b_indicator;
    logic phase_c_indicator;
  } pfm_led_type;
endpackage : pfm_pkg
`default_nettype wire

// file: hw/pfm_timer.sv
// per-phase zero-crossing timeout and return qualifier
`default_nettype none
module pfm_timer
  import pfm_pkg::*;
#(
  parameter int LIMIT = DROP_CYC
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic zc,
  input wire logic amp_ok,
  output logic dropout
);
  localparam int CW = $clog2(LIMIT + 2);
  logic [CW-1:0] gap_r, gap_nxt;
  logic [CW-1:0] good_r, good_nxt;
  // low amplitude: timer of its own so indication also lands at ~150 ms
  logic [CW-1:0] low_r, low_nxt;
  logic drop_r, drop_nxt;

  always_comb
  begin
    gap_nxt = gap_r;
    good_nxt = good_r;
    low_nxt = low_r;
    drop_nxt = drop_r;
    if (zc)
      gap_nxt = '0;
    else if (gap_r <= CW'(LIMIT))
      gap_nxt = gap_r + 1'b1;
    // qualified time with crossings and amplitude present
    if (!amp_ok || gap_r > CW'(LIMIT))
      good_nxt = '0;
    else if (good_r <= CW'(LIMIT))
      good_nxt = good_r + 1'b1;
    if (amp_ok)
      low_nxt = '0;
    else if (low_r <= CW'(LIMIT))
      low_nxt = low_r + 1'b1;
    if (drop_r && good_r > CW'(LIMIT))
      drop_nxt = 1'b0;
    // a fresh timeout wins over a clear in the same cycle
    if (gap_r > CW'(LIMIT) || low_r == CW'(LIMIT))
      drop_nxt = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      gap_r <= '0;
      good_r <= '0;
      drop_r <= 1'b0;
      low_r <= '0;
    end
    else
    begin
      gap_r <= gap_nxt;
      good_r <= good_nxt;
      low_r <= low_nxt;
      drop_r <= drop_nxt;
    end
  end

  assign dropout = drop_r;

  chk_drop_clear: assert property (@(posedge core_clk)
    disable iff (rst) $fell(drop_r) |-> $past(good_r) > CW'(LIMIT))
    else $error("dropout cleared without qualified return");
  chk_drop_timeout: assert property (@(posedge core_clk)
    disable iff (rst) gap_r > CW'(LIMIT) |=> drop_r)
    else $error("missing crossing did not raise dropout");
endmodule : pfm_timer
`default_nettype wire

// file: tb/pfm_led_model.sv
// led pair model: latches which led of each pin pair is lit
`default_nettype none
module pfm_led_model
  import pfm_pkg::*;
(
  input wire logic core_clk,
  input wire pfm_led_type led,
  output logic [2:0] drop_lit,
  output logic [2:0] rev_lit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] pins;
  assign pins = {led.phase_c_indicator, led.phase_b_indicator,
    led.phase_a_indicator};
  initial drop_lit = 3'h0;
  initial rev_lit = 3'h0;
  always @(posedge core_clk)
  begin
    if (led.indicator_select)
      drop_lit <= ~pins;
    else
      rev_lit <= pins;
  end
endmodule : pfm_led_model
`default_nettype wire

// file: tb/pfm_monitor_tb_top.sv
// self-checking bench for the phase fault monitor
`default_nettype none
module pfm_monitor_tb_top
  import pfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DL = 50;
  localparam int BH = 20;
  localparam int SH = 2;
  localparam int FT = 2;
  logic core_clk = 1'b0;
  logic rst;
  logic supply_above, supply_below, ref_above;
  logic [2:0] zc = 3'h0;
  logic [2:0] zc_n;
  logic [2:0] amp, neg, mask;
  logic signed [PWR_W-1:0] power_a, power_b, power_c;
  pfm_phase_in_type phase_in;
  pfm_led_type led;
  logic signed [PWR_W+1:0] total_power;
  logic datapath_rst;
  logic [2:0] drop_lit, rev_lit, d_or, d_and, r_and;
  int err_count = 0;
  int n_checks = 0;
  int gap_cnt = 0;
  int idx = 0;
  int tog;
  int ord [3] = '{0, 1, 2};
  assign phase_in = '{zero_cross: zc, amp_ok: amp, power_neg: neg};
  always #20 core_clk = ~core_clk;
  pfm_monitor #(.DROP_LIMIT(DL), .BLINK_HALF(BH), .SEL_HALF(SH),
    .FILT(FT)) pfm_monitor_i (
    .core_clk(core_clk), .rst(rst), .supply_above(supply_above),
    .supply_below(supply_below), .ref_above(ref_above),
    .phase_in(phase_in), .power_a(power_a), .power_b(power_b),
    .power_c(power_c), .led(led), .total_power(total_power),
    .datapath_rst(datapath_rst));
  pfm_led_model pfm_led_model_i (.core_clk(core_clk), .led(led),
    .drop_lit(drop_lit), .rev_lit(rev_lit));
  ////////////////////////////////////////////////////////////////////////
  // one crossing every ten cycles, in the order held by ord
  // worked out at the edge, so mask and ord set at #1 never race it
  always @(posedge core_clk)
  begin
    zc_n = (gap_cnt == 9) ? (mask & (3'h1 << ord[idx])) : 3'h0;
    if (gap_cnt == 9)
      idx = (idx + 1) % 3;
    gap_cnt = (gap_cnt + 1) % 10;
    #1;
    zc = zc_n;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic signed [PWR_W+1:0] exp_total(
    input logic signed [PWR_W-1:0] a, b, c);
    return (PWR_W+2)'(a) + (PWR_W+2)'(b) + (PWR_W+2)'(c);
  endfunction : exp_total
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
    end
  endtask : cyc
  task automatic rnd_power;
    power_a = PWR_W'($urandom);
    power_b = PWR_W'($urandom);
    power_c = PWR_W'($urandom);
  endtask : rnd_power
  // or and and of the drop lit flags, and of the reverse lit flags, over n cycles, plus select toggles
  task automatic watch(input int n);
    logic prev;
    d_or = 3'h0;
    d_and = 3'h7;
    r_and = 3'h7;
    tog = 0;
    prev = led.indicator_select;
    repeat (n)
    begin
      cyc(1);
      d_or = d_or | drop_lit;
      d_and = d_and & drop_lit;
      r_and = r_and & rev_lit;
      tog = tog + int'(led.indicator_select !== prev);
      prev = led.indicator_select;
    end
  endtask : watch
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(40 * 12000);
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    logic [2:0] e;
    rst = 1'b1;
    supply_above = 1'b0;
    supply_below = 1'b1;
    ref_above = 1'b0;
    amp = 3'h7;
    neg = 3'h0;
    mask = 3'h7;
    power_a = '0;
    power_b = '0;
    power_c = '0;
    void'($urandom(32'h09C0));
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b0;
    cyc(10);
    check(datapath_rst, 1);
    check({led, total_power}, 0);
    supply_above = 1'b1;
    supply_below = 1'b0;
    ref_above = 1'b1;
    cyc(FT + 5);
    check(datapath_rst, 0);
    $display("test supply up done");
    repeat (8)
    begin
      rnd_power();
      cyc(2);
      check(total_power, exp_total(power_a, power_b, power_c));
    end
    $display("test power sum done");
    cyc(200);
    watch(40);
    check(d_or, 0);
    check(tog, 40 / SH);
    repeat (4)
    begin
      neg = 3'($urandom);
      cyc(6);
      watch(8);
      check(r_and, neg);
    end
    $display("test reverse done");
    for (int k = 0; k < 2; k++)
    begin
      e = (k == 0) ? 3'h2 : 3'h1;
      neg = e;
      if (k == 0)
        mask = 3'h5;
      else
        amp = 3'h6;
      cyc(10);
      watch(10);
      check(d_or, 0);
      cyc(80);
      rnd_power();
      watch(10);
      check({d_or, d_and}, {e, e});
      check(r_and, e);
      check(total_power, exp_total(power_a, power_b, power_c));
      mask = 3'h7;
      amp = 3'h7;
      cyc(20);
      watch(10);
      check(d_and, e);
      cyc(100);
      watch(10);
      check(d_or, 0);
      $display("test dropout %0d done", k);
    end
    ord = '{0, 2, 1};
    watch(20);
    check(d_or, 0);
    neg = 3'h2;
    cyc(80);
    watch(80);
    check({d_or, d_and}, {3'h7, 3'h0});
    check(r_and, 3'h2);
    mask = 3'h3;
    cyc(100);
    watch(40);
    check({d_or, d_and}, {3'h4, 3'h4});
    $display("test sequence done");
    supply_below = 1'b1;
    cyc(1);
    supply_below = 1'b0;
    cyc(6);
    check(datapath_rst, 0);
    ref_above = 1'b0;
    cyc(FT + 6);
    check(datapath_rst, 1);
    check({led, total_power}, 0);
    $display("test supply down done");
    tally_and_finish();
  end
endmodule : pfm_monitor_tb_top
`default_nettype wire
